// ### hw/cir_router.sv
// Top of the CAN interrupt router: APB register file, three module units, pin combining.
// Assumes protocol cores drive one-cycle event pulses on clk and pins enter unsynchronised.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Five source types per module exist.
// - Split select picks combined or separate requests.
// - Slot completion sets its slot status bit.
// - Error events set matching error status bits.
// - Combined request is any masked status bit.
// - Combined rising edge sets all three flags.
// - Enabled vector flag sets processor pending bit.
// - Held request gives no new edge.
// - Status and flags clear only by software.
// - Uncleared bits block new combined requests.
// - Receive request from masked receive slots.
// - Transmit request from masked transmit slots.
// - Error request from masked error bits.
// - Split edges set flags 0,1,2 respectively.
// - Held error request leaves flags unchanged.
// - Receive/transmit acknowledge needs only flag clear; the code also needs the masked slot status bits cleared.
// - Error acknowledge needs flag and status cleared.
// - Combination mode merges transmit, shares receive.
// - Different identifiers arbitrate through shared bus.
// - Idle controller acknowledges partner's frame.
// - Each controller keeps its own vectors.
// - Error counters may diverge in this mode.
module cir_router
  import cir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`CIR_NUM_SLOTS-1:0] tx_done0,
  input wire logic [`CIR_NUM_SLOTS-1:0] rx_done0,
  input wire logic [`CIR_NUM_ERRS-1:0] err_event0,
  input wire logic [`CIR_NUM_SLOTS-1:0] tx_done1,
  input wire logic [`CIR_NUM_SLOTS-1:0] rx_done1,
  input wire logic [`CIR_NUM_ERRS-1:0] err_event1,
  input wire logic [`CIR_NUM_SLOTS-1:0] tx_done2,
  input wire logic [`CIR_NUM_SLOTS-1:0] rx_done2,
  input wire logic [`CIR_NUM_ERRS-1:0] err_event2,
  input wire logic core0_tx_n,
  input wire logic core2_tx_n,
  output logic combined_tx_pin,
  input wire logic combined_rx_pin,
  input wire logic core0_rx_pin,
  input wire logic core2_rx_pin,
  output logic core0_rx,
  output logic core2_rx,
  output logic [8:0] vector_pending_bit
);
  logic [2:0] split_sel;
  logic combine_mode;
  logic [`CIR_NUM_SLOTS-1:0] ev_tx [3];
  logic [`CIR_NUM_SLOTS-1:0] ev_rx [3];
  logic [`CIR_NUM_ERRS-1:0] ev_err [3];
  cir_slot_vec_t slot_status [3];
  cir_slot_vec_t slot_mask [3];
  cir_slot_vec_t slot_dir [3];
  cir_err_vec_t err_status [3];
  cir_err_vec_t err_mask [3];
  cir_vec_t vec_request [3];
  cir_vec_t vec_enable [3];
  cir_vec_t req_level [3];
  cir_vec_t pending_set [3];
  logic [8:0] pending_clr;
  logic [8:0] next_pending;
  logic access;
  logic ack;
  logic wr_en;
  logic [1:0] mod_idx;
  logic [11:0] mod_off;
  logic in_module;
  logic in_global;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] next_prdata;
  logic [2:0] sync_a;
  logic [2:0] sync_b;

  // Module index selection from a byte address.
  function automatic logic [1:0] mod_of(input logic [11:0] a);
    mod_of = a[7:6];
  endfunction

  // Register byte offset within a module window.
  function automatic logic [11:0] off_of(input logic [11:0] a);
    off_of = {6'h00, a[5:0]};
  endfunction

  // Bus decode: one wait state, so read data already stands in its flop when pready rises.
  assign access = psel & penable;
  assign wr_en = access & pwrite & ack;
  assign mod_idx = mod_of(paddr);
  assign mod_off = off_of(paddr);
  assign in_module = (paddr < `CIR_GLOBAL_BASE) && (mod_off <= `CIR_OFF_REQ_LEVEL) && (paddr[1:0] == 2'h0);
  assign in_global = (paddr == (`CIR_GLOBAL_BASE + `CIR_OFF_COMBINE));
  assign addr_ok = in_module | in_global;
  assign pready = ack;
  assign pslverr = access & ack & ~addr_ok;

  // Sources routed to each module; module 1 has no combination role.
  assign ev_tx[0] = tx_done0;
  assign ev_tx[1] = tx_done1;
  assign ev_tx[2] = tx_done2;
  assign ev_rx[0] = rx_done0;
  assign ev_rx[1] = rx_done1;
  assign ev_rx[2] = rx_done2;
  assign ev_err[0] = err_event0;
  assign ev_err[1] = err_event1;
  assign ev_err[2] = err_event2;

  // One unit per module; each keeps its own three vectors in combination mode too.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_mod
      logic sel;
      assign sel = wr_en & in_module & (mod_idx == 2'(g));
      cir_module_unit u_unit (
        .clk(clk),
        .rst(rst),
        .split_sel(split_sel[g]),
        .tx_done(ev_tx[g]),
        .rx_done(ev_rx[g]),
        .err_event(ev_err[g]),
        .wr_slot_status(sel & (mod_off == `CIR_OFF_SLOT_STATUS)),
        .wr_slot_mask(sel & (mod_off == `CIR_OFF_SLOT_MASK)),
        .wr_err_status(sel & (mod_off == `CIR_OFF_ERROR_STATUS)),
        .wr_err_mask(sel & (mod_off == `CIR_OFF_ERROR_MASK)),
        .wr_vec_request(sel & (mod_off == `CIR_OFF_VEC_REQUEST)),
        .wr_vec_enable(sel & (mod_off == `CIR_OFF_VEC_ENABLE)),
        .wdata(pwdata),
        .slot_status(slot_status[g]),
        .slot_mask(slot_mask[g]),
        .slot_dir(slot_dir[g]),
        .err_status(err_status[g]),
        .err_mask(err_mask[g]),
        .vec_request(vec_request[g]),
        .vec_enable(vec_enable[g]),
        .req_level(req_level[g]),
        .pending_set(pending_set[g])
      );
      assign pending_clr[3*g +: 3] = (sel & (mod_off == `CIR_OFF_PENDING))
        ? ~pwdata[2:0] : 3'h0;
    end
  endgenerate

  // Pending bits: enabled flag rises set them, software writes 0 to clear; set wins.
  assign next_pending = (vector_pending_bit & ~pending_clr)
    | {pending_set[2], pending_set[1], pending_set[0]};

  // Read mux over the module windows and the global register.
  always_comb begin
    rd_mux = `CIR_RESET_WORD;
    if (in_global) begin
      rd_mux = {31'h0, combine_mode};
    end else if (in_module && mod_idx != 2'h3) begin
      case (mod_off)
        `CIR_OFF_CTRL: rd_mux = {31'h0, split_sel[mod_idx]};
        `CIR_OFF_SLOT_STATUS: rd_mux = {16'h0, slot_status[mod_idx]};
        `CIR_OFF_SLOT_MASK: rd_mux = {16'h0, slot_mask[mod_idx]};
        `CIR_OFF_ERROR_STATUS: rd_mux = {29'h0, err_status[mod_idx]};
        `CIR_OFF_ERROR_MASK: rd_mux = {29'h0, err_mask[mod_idx]};
        `CIR_OFF_SLOT_DIR: rd_mux = {16'h0, slot_dir[mod_idx]};
        `CIR_OFF_VEC_REQUEST: rd_mux = {29'h0, vec_request[mod_idx]};
        `CIR_OFF_VEC_ENABLE: rd_mux = {29'h0, vec_enable[mod_idx]};
        `CIR_OFF_PENDING: rd_mux = {29'h0, vector_pending_bit[3*mod_idx +: 3]};
        `CIR_OFF_REQ_LEVEL: rd_mux = {29'h0, req_level[mod_idx]};
        default: rd_mux = `CIR_RESET_WORD;
      endcase
    end
  end
  assign next_prdata = (access & ~pwrite & ~ack) ? rd_mux : prdata;

  // Control registers: split select per module and the combination mode bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      split_sel <= 3'h0;
      combine_mode <= 1'b0;
    end else if (wr_en) begin
      if (in_module && mod_off == `CIR_OFF_CTRL && mod_idx != 2'h3)
        split_sel[mod_idx] <= pwdata[`CIR_CTRL_SPLIT_BIT];
      if (in_global)
        combine_mode <= pwdata[0];
    end
  end

  // Pending bits, read data and the wait-state flag that completes each access.
  always_ff @(posedge clk) begin
    if (rst) begin
      vector_pending_bit <= 9'h000;
      prdata <= `CIR_RESET_WORD;
      ack <= 1'b0;
    end else begin
      vector_pending_bit <= next_pending;
      prdata <= next_prdata;
      ack <= access & ~ack;
    end
  end

  // Two-stage synchronisers for the three receive pins.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {core2_rx_pin, core0_rx_pin, combined_rx_pin};
      sync_b <= sync_a;
    end
  end

  // Combination mode: both cores see the shared line, which also carries their own
  // wired-AND bits, so arbitration and cross acknowledgement happen naturally.
  assign core0_rx = combine_mode ? sync_b[0] : sync_b[1];
  assign core2_rx = combine_mode ? sync_b[0] : sync_b[2];

  // Merged transmit: dominant low wins, plain AND; core 0 alone when not combined.
  assign combined_tx_pin = combine_mode ? (core0_tx_n & core2_tx_n) : core0_tx_n;
endmodule
`default_nettype wire

// ### hw/cir_params.svh
// Constants for the CAN interrupt router: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the router package or modules.
`ifndef CIR_PARAMS_SVH
`define CIR_PARAMS_SVH
`define CIR_NUM_MODULES 3
`define CIR_NUM_SLOTS 16
`define CIR_NUM_ERRS 3
`define CIR_ERR_BUS 0
`define CIR_ERR_PASSIVE 1
`define CIR_ERR_BUSOFF 2
`define CIR_OFF_CTRL 12'h000
`define CIR_OFF_SLOT_STATUS 12'h004
`define CIR_OFF_SLOT_MASK 12'h008
`define CIR_OFF_ERROR_STATUS 12'h00C
`define CIR_OFF_ERROR_MASK 12'h010
`define CIR_OFF_SLOT_DIR 12'h014
`define CIR_OFF_VEC_REQUEST 12'h018
`define CIR_OFF_VEC_ENABLE 12'h01C
`define CIR_OFF_PENDING 12'h020
`define CIR_OFF_REQ_LEVEL 12'h024
`define CIR_MODULE_STRIDE 12'h040
`define CIR_GLOBAL_BASE 12'h0C0
`define CIR_OFF_COMBINE 12'h000
`define CIR_CTRL_SPLIT_BIT 0
`define CIR_RESET_WORD 32'h0000_0000
`endif

// ### hw/cir_pkg.sv
// Types shared by the CAN interrupt router.
// Assumes the constants header is available on the include path.
`include "cir_params.svh"
package cir_pkg;
  typedef logic [`CIR_NUM_SLOTS-1:0] cir_slot_vec_t;
  typedef logic [`CIR_NUM_ERRS-1:0] cir_err_vec_t;
  typedef logic [2:0] cir_vec_t;
  typedef enum logic [1:0] {
    CIR_VEC_RX,
    CIR_VEC_TX,
    CIR_VEC_ERR
  } cir_vec_idx_t;
endpackage

// ### hw/cir_module_unit.sv
// One CAN module's status, mask, request and vector flag logic.
// Assumes event inputs are single-cycle pulses from logic on clk and software writes come decoded.
`timescale 1ns/1ps
`default_nettype none
module cir_module_unit
  import cir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic split_sel,
  input wire cir_slot_vec_t tx_done,
  input wire cir_slot_vec_t rx_done,
  input wire cir_err_vec_t err_event,
  input wire logic wr_slot_status,
  input wire logic wr_slot_mask,
  input wire logic wr_err_status,
  input wire logic wr_err_mask,
  input wire logic wr_vec_request,
  input wire logic wr_vec_enable,
  input wire logic [31:0] wdata,
  output cir_slot_vec_t slot_status,
  output cir_slot_vec_t slot_mask,
  output cir_slot_vec_t slot_dir,
  output cir_err_vec_t err_status,
  output cir_err_vec_t err_mask,
  output cir_vec_t vec_request,
  output cir_vec_t vec_enable,
  output cir_vec_t req_level,
  output cir_vec_t pending_set
);
  cir_slot_vec_t next_slot_status;
  cir_slot_vec_t next_slot_dir;
  cir_err_vec_t next_err_status;
  cir_vec_t next_vec_request;
  cir_vec_t req_prev;
  cir_vec_t req_rise;
  cir_slot_vec_t slot_hit;
  logic rx_req;
  logic tx_req;
  logic err_req;
  logic comb_req;

  // Status bits: events set, software writes 0 to clear; a set in the same cycle wins.
  assign next_slot_status = (wr_slot_status ? (slot_status & wdata[`CIR_NUM_SLOTS-1:0]) : slot_status)
    | tx_done | rx_done;
  assign next_err_status = (wr_err_status ? (err_status & wdata[`CIR_NUM_ERRS-1:0]) : err_status)
    | err_event;
  // Direction memory: 1 marks a slot last set by a transmission.
  assign next_slot_dir = (slot_dir & ~rx_done) | tx_done;

  // Masked request levels for both request styles.
  assign slot_hit = slot_status & slot_mask;
  assign rx_req = |(slot_hit & ~slot_dir);
  assign tx_req = |(slot_hit & slot_dir);
  assign err_req = |(err_status & err_mask);
  assign comb_req = |slot_hit | err_req;
  assign req_level = split_sel ? {err_req, tx_req, rx_req} : {3{comb_req}};

  // Single-cycle rising edge pulses per request line; a held level gives none.
  assign req_rise = req_level & ~req_prev;
  assign next_vec_request = (wr_vec_request ? (vec_request & wdata[2:0]) : vec_request) | req_rise;
  assign pending_set = next_vec_request & ~vec_request & vec_enable;

  // Status, error status and direction registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_status <= '0;
      slot_dir <= '0;
      err_status <= '0;
    end else begin
      slot_status <= next_slot_status;
      slot_dir <= next_slot_dir;
      err_status <= next_err_status;
    end
  end

  // Mask and enable registers written by software.
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_mask <= '0;
      err_mask <= '0;
      vec_enable <= '0;
    end else begin
      if (wr_slot_mask) slot_mask <= wdata[`CIR_NUM_SLOTS-1:0];
      if (wr_err_mask) err_mask <= wdata[`CIR_NUM_ERRS-1:0];
      if (wr_vec_enable) vec_enable <= wdata[2:0];
    end
  end

  // Vector flags and the delayed request copy for edge detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_request <= '0;
      req_prev <= '0;
    end else begin
      vec_request <= next_vec_request;
      req_prev <= req_level;
    end
  end
endmodule
`default_nettype wire

// ### testbench/cir_router_properties.sv
// Checker for the router pins: transmit merge, receive paths and causes of pending bits.
// Assumes it is bound into cir_router with ports of the same names.
`timescale 1ns/1ps
`default_nettype none
module cir_router_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] tx_done0,
  input wire logic [15:0] rx_done0,
  input wire logic [2:0] err_event0,
  input wire logic [15:0] tx_done1,
  input wire logic [15:0] rx_done1,
  input wire logic [2:0] err_event1,
  input wire logic [15:0] tx_done2,
  input wire logic [15:0] rx_done2,
  input wire logic [2:0] err_event2,
  input wire logic core0_tx_n,
  input wire logic core2_tx_n,
  input wire logic combined_tx_pin,
  input wire logic combined_rx_pin,
  input wire logic core0_rx_pin,
  input wire logic core2_rx_pin,
  input wire logic core0_rx,
  input wire logic core2_rx,
  input wire logic [8:0] vector_pending_bit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Write accesses and per-module core activity, the only legal causes of a new pending bit.
  wire wr_acc = psel & penable & pwrite;
  wire ev0 = |{tx_done0, rx_done0, err_event0};
  wire ev1 = |{tx_done1, rx_done1, err_event1};
  wire ev2 = |{tx_done2, rx_done2, err_event2};
  // A pending group gains a bit, and what may have caused it.
  sequence s_rise(v);
    |(v & ~$past(v));
  endsequence
  sequence s_cause(e);
    $past(e, 2) || $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3);
  endsequence
  property p_tx_dom;
    !core0_tx_n |-> !combined_tx_pin;
  endproperty
  a_tx_dom: assert property (p_tx_dom) else $error("merged transmit not dominant");
  property p_tx_rec;
    core0_tx_n && core2_tx_n |-> combined_tx_pin;
  endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("merged transmit not recessive");
  property p_rx0;
    !$past(rst) && !$past(rst, 2) |-> core0_rx == $past(combined_rx_pin, 2) || core0_rx == $past(core0_rx_pin, 2);
  endproperty
  a_rx0: assert property (p_rx0) else $error("core 0 receive path wrong");
  property p_rx2;
    !$past(rst) && !$past(rst, 2) |-> core2_rx == $past(combined_rx_pin, 2) || core2_rx == $past(core2_rx_pin, 2);
  endproperty
  a_rx2: assert property (p_rx2) else $error("core 2 receive path wrong");
  property p_pend_keep;
    |($past(vector_pending_bit) & ~vector_pending_bit) |-> $past(wr_acc);
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("pending bit cleared by itself");
  property p_pend_m0;
    s_rise(vector_pending_bit[2:0]) |-> s_cause(ev0);
  endproperty
  a_pend_m0: assert property (p_pend_m0) else $error("module 0 pending without cause");
  property p_pend_m1;
    s_rise(vector_pending_bit[5:3]) |-> s_cause(ev1);
  endproperty
  a_pend_m1: assert property (p_pend_m1) else $error("module 1 pending without cause");
  property p_pend_m2;
    s_rise(vector_pending_bit[8:6]) |-> s_cause(ev2);
  endproperty
  a_pend_m2: assert property (p_pend_m2) else $error("module 2 pending without cause");
endmodule
bind cir_router cir_router_checker u_cir_router_checker (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .tx_done0(tx_done0), .rx_done0(rx_done0), .err_event0(err_event0), .tx_done1(tx_done1),
  .rx_done1(rx_done1), .err_event1(err_event1), .tx_done2(tx_done2), .rx_done2(rx_done2),
  .err_event2(err_event2), .core0_tx_n(core0_tx_n), .core2_tx_n(core2_tx_n), .combined_tx_pin(combined_tx_pin),
  .combined_rx_pin(combined_rx_pin), .core0_rx_pin(core0_rx_pin), .core2_rx_pin(core2_rx_pin),
  .core0_rx(core0_rx), .core2_rx(core2_rx), .vector_pending_bit(vector_pending_bit));
`default_nettype wire

// ### testbench/cir_core_model.sv
// Stand-in for the three protocol cores: completion and error pulses, transmit and bus levels.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cir_core_model (
  input wire logic clk,
  output logic [2:0][15:0] tx_done,
  output logic [2:0][15:0] rx_done,
  output logic [2:0][2:0] err_event,
  output logic core0_tx_n,
  output logic core2_tx_n,
  output logic rx_bus
);
  // Idle cores: no events, recessive lines.
  initial begin
    tx_done = '0;
    rx_done = '0;
    err_event = '0;
    core0_tx_n = 1'b1;
    core2_tx_n = 1'b1;
    rx_bus = 1'b1;
  end
  // One-cycle event: kind 0 transmit done, 1 receive done, 2 error bit b.
  task automatic fire(input int m, input int kind, input int b);
    if (kind == 0) tx_done[m][b] <= 1'b1;
    else if (kind == 1) rx_done[m][b] <= 1'b1;
    else err_event[m][b] <= 1'b1;
    @(posedge clk);
    tx_done <= '0;
    rx_done <= '0;
    err_event <= '0;
  endtask
  // Line levels, low dominant; both cores share timing and never send one identifier.
  task automatic drive(input logic t0, input logic t2, input logic rx);
    core0_tx_n <= t0;
    core2_tx_n <= t2;
    rx_bus <= rx;
  endtask
endmodule
`default_nettype wire

// ### testbench/test_cir_router.sv
// Self-checking bench: APB register traffic with core events from the model.
// Assumes design, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_cir_router;
  import cir_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, tx0_n, tx2_n, rx_bus, tx_pin, c0_rx, c2_rx, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0][15:0] txd, rxd;
  logic [2:0][2:0] erv;
  logic [8:0] pend;
  int mismatches = 0;
  int samples_checked = 0;
  cir_router u_cir_router (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_done0(txd[0]),
    .rx_done0(rxd[0]), .err_event0(erv[0]), .tx_done1(txd[1]), .rx_done1(rxd[1]), .err_event1(erv[1]),
    .tx_done2(txd[2]), .rx_done2(rxd[2]), .err_event2(erv[2]), .core0_tx_n(tx0_n), .core2_tx_n(tx2_n),
    .combined_tx_pin(tx_pin), .combined_rx_pin(rx_bus), .core0_rx_pin(1'b1), .core2_rx_pin(1'b1),
    .core0_rx(c0_rx), .core2_rx(c2_rx), .vector_pending_bit(pend));
  cir_core_model u_cir_core_model (.clk(clk), .tx_done(txd), .rx_done(rxd), .err_event(erv),
    .core0_tx_n(tx0_n), .core2_tx_n(tx2_n), .rx_bus(rx_bus));
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counts a comparison and reports a difference at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One APB transfer; read data and the error flag are taken at the edge that samples pready high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      close_out();
    end
    rerr = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Reads a register and compares it.
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask
  // Fires one core event and compares all pending bits once the flags have settled.
  task automatic ev(input int m, input int k, input int b, input logic [8:0] exp);
    u_cir_core_model.fire(m, k, b);
    repeat (3) @(posedge clk);
    chk("pending", {23'h0, exp}, {23'h0, pend});
  endtask
  // Single request style on modules 0 and 2; a held request gives no second edge.
  task automatic t_single;
    logic [11:0] b;
    logic [8:0] all;
    for (int m = 0; m < 3; m += 2) begin
      b = 12'(m * 64);
      all = 9'(7 << (3 * m));
      apb(1'b1, b + 12'h008, 32'h8);
      apb(1'b1, b + 12'h01C, 32'h7);
      ev(m, 0, 3, all);
      rd("slot status", b + 12'h004, 32'h8);
      apb(1'b1, b + 12'h018, 32'h0);
      apb(1'b1, b + 12'h020, 32'h0);
      ev(m, 1, 3, 9'h000);
      apb(1'b1, b + 12'h004, 32'h0);
      ev(m, 1, 3, all);
      apb(1'b1, b + 12'h004, 32'h0);
      apb(1'b1, b + 12'h018, 32'h0);
      apb(1'b1, b + 12'h020, 32'h0);
    end
    $display("test single done");
  endtask
  // Separate requests on module 1.
  task automatic t_split;
    apb(1'b1, 12'h040, 32'h1);
    apb(1'b1, 12'h048, 32'h0000FFFF);
    apb(1'b1, 12'h050, 32'h7);
    apb(1'b1, 12'h05C, 32'h7);
    ev(1, 1, 0, 9'h008);
    ev(1, 0, 1, 9'h018);
    ev(1, 2, 1, 9'h038);
    rd("error status", 12'h04C, 32'h2);
    apb(1'b1, 12'h058, 32'h3);
    apb(1'b1, 12'h060, 32'h3);
    rd("slot status", 12'h044, 32'h3);
    ev(1, 2, 2, 9'h018);
    rd("error status", 12'h04C, 32'h6);
    apb(1'b1, 12'h04C, 32'h0);
    ev(1, 2, 0, 9'h038);
    $display("test split done");
  endtask
  // Shared pins of cores 0 and 2, then an unmapped access.
  task automatic t_pins;
    apb(1'b1, 12'h0C0, 32'h1);
    u_cir_core_model.drive(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    chk("tx pin", 32'h0, {31'h0, tx_pin});
    u_cir_core_model.drive(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk("tx pin", 32'h0, {31'h0, tx_pin});
    chk("rx path", 32'h0, {30'h0, c0_rx, c2_rx});
    u_cir_core_model.drive(1'b1, 1'b1, 1'b1);
    apb(1'b1, 12'h0C0, 32'h0);
    u_cir_core_model.drive(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    chk("tx pin", 32'h1, {31'h0, tx_pin});
    repeat (2) @(posedge clk);
    chk("rx path", 32'h3, {30'h0, c0_rx, c2_rx});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    $display("test pins done");
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_single();
    t_split();
    t_pins();
    close_out();
  end
endmodule
`default_nettype wire
